// [pkg/nvr_pkg.sv]
// Contract
// - 1 kbit storage, eight banks of 128 bits
// - Each bank read as sixteen bytes
// - Programming only through JTAG test port
// - Rewrite whole banks; others stay unchanged
// - Bank erased automatically before each rewrite
// - Synchronous read, one aligned byte each
// - Upper three address bits select bank
// - Lower four address bits select byte
// - Address at rise, data valid by fall
// - Each rise restarts read; invalid then valid
package nvr_pkg;
    localparam int NVR_BANKS = 8;
    localparam int NVR_BANK_BITS = 128;
    localparam int NVR_BYTES = 16;
    localparam int NVR_BANK_AW = 3;
    localparam int NVR_BYTE_AW = 4;
    localparam int NVR_ADDR_W = 7;
    localparam int NVR_DATA_W = 8;
    localparam int NVR_BANK_MSB = 6;
    localparam int NVR_BANK_LSB = 4;
    localparam int NVR_BYTE_MSB = 3;
    localparam int NVR_BYTE_LSB = 0;
    localparam logic [7:0] NVR_ERASED_BYTE = 8'h00;
    localparam logic [7:0] NVR_CLEAR_BYTE = 8'h00;
    typedef logic [NVR_ADDR_W-1:0] nvr_addr_t;
    typedef logic [NVR_DATA_W-1:0] nvr_byte_t;
    typedef logic [NVR_BANK_AW-1:0] nvr_bank_t;
    typedef logic [NVR_BANK_BITS-1:0] nvr_bank_word_t;
    typedef enum logic [1:0] {NVR_PG_IDLE, NVR_PG_ERASE, NVR_PG_WRITE} nvr_pg_state_t;
endpackage : nvr_pkg

// [pkg/nvr_prog_if.sv]
`timescale 1ns/1ns
`default_nettype none
// Bank write port from the JTAG programming side into the store
interface nvr_prog_if;
    import nvr_pkg::*;
    logic erase;
    logic write;
    nvr_bank_t bank;
    nvr_bank_word_t data;
    modport ctrl (output erase, output write, output bank, output data);
    modport store (input erase, input write, input bank, input data);
endinterface : nvr_prog_if
`default_nettype wire

// [src/nvr_bank_store.sv]
`timescale 1ns/1ns
`default_nettype none
// Eight 128-bit banks in flip-flops; only the programming port writes
module nvr_bank_store
    import nvr_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rstn_i, // Synchronised reset, active low
    nvr_prog_if.store prog, // Bank erase/write port
    input wire nvr_addr_t addr_i, // Read address
    output nvr_byte_t rdata_o // Combinational byte
);
    import nvr_pkg::*;
    typedef struct packed {
        nvr_bank_word_t [NVR_BANKS-1:0] bank;
    } nvr_st_t;
    nvr_st_t st_reg;
    nvr_st_t st_next;
    nvr_bank_word_t sel_word;

    // Only the addressed bank changes; others hold
    always_comb begin
        st_next = st_reg;
        if (prog.erase) begin
            st_next.bank[prog.bank] = {NVR_BYTES{NVR_ERASED_BYTE}};
        end else if (prog.write) begin
            st_next.bank[prog.bank] = prog.data;
        end
    end

    // Contents survive reset, as nonvolatile storage should
    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    // Bank by upper bits, byte by lower bits
    always_comb begin
        sel_word = st_reg.bank[addr_i[NVR_BANK_MSB:NVR_BANK_LSB]];
        rdata_o = sel_word[addr_i[NVR_BYTE_MSB:NVR_BYTE_LSB]*NVR_DATA_W +: NVR_DATA_W];
    end

    // Neighbour bank must hold; unprogrammed banks are unknown, hence case equality
    chk_other_banks_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prog.write || prog.erase) |=> (st_reg.bank[$past(prog.bank) + 3'h1]
            === $past(st_reg.bank[prog.bank + 3'h1])))
        else $error("Unselected bank changed");
    chk_write_stores: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prog.write && !prog.erase) |=> (st_reg.bank[$past(prog.bank)] == $past(prog.data)))
        else $error("Bank write lost");
    chk_erase_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
        prog.erase |=> (st_reg.bank[$past(prog.bank)] == {NVR_BYTES{NVR_ERASED_BYTE}}))
        else $error("Bank not erased");
endmodule : nvr_bank_store
`default_nettype wire

// [src/nvr_byte_store.sv]
`timescale 1ns/1ns
`default_nettype none
// Read port plus test-port bank programming with automatic erase
module nvr_byte_store
    import nvr_pkg::*;
(
    input wire logic clk_i, // Access clock
    input wire logic rstn_i, // Async reset, active low
    input wire nvr_pkg::nvr_addr_t addr_i, // Read address
    output nvr_pkg::nvr_byte_t first_read_byte_o, // Read byte
    output logic valid_o, // High in low phase when byte valid
    input wire logic jtag_prog_i, // Test-port bank program strobe
    input wire nvr_pkg::nvr_bank_t jtag_bank_i, // Bank to program
    input wire nvr_pkg::nvr_bank_word_t jtag_data_i, // New bank contents
    output logic jtag_busy_o // Programming in progress
);
    import nvr_pkg::*;

    typedef struct packed {
        nvr_pg_state_t state;
        nvr_bank_t bank;
        nvr_bank_word_t data;
        logic busy;
    } nvr_top_t;

    logic rst_s1_reg;
    logic rst_s2_reg;
    nvr_top_t st_reg;
    nvr_top_t st_next;
    nvr_byte_t rd_byte;
    nvr_byte_t dout_reg;
    logic rise_tog_reg;
    logic fall_tog_reg;
    nvr_prog_if prog ();

    // Release reset through two flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Program sequence: capture, erase bank, then write bank
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            NVR_PG_IDLE: begin
                if (jtag_prog_i) begin
                    st_next.bank = jtag_bank_i;
                    st_next.data = jtag_data_i;
                    st_next.busy = 1'b1;
                    st_next.state = NVR_PG_ERASE;
                end
            end
            NVR_PG_ERASE: begin
                st_next.state = NVR_PG_WRITE;
            end
            NVR_PG_WRITE: begin
                st_next.busy = 1'b0;
                st_next.state = NVR_PG_IDLE;
            end
            default: begin
                st_next.state = NVR_PG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            st_reg <= '{state: NVR_PG_IDLE, bank: '0, data: '0, busy: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Only the test-port sequencer drives the store; no core write path
    assign prog.erase = (st_reg.state == NVR_PG_ERASE);
    assign prog.write = (st_reg.state == NVR_PG_WRITE);
    assign prog.bank = st_reg.bank;
    assign prog.data = st_reg.data;

    nvr_bank_store u_store (
        .clk_i(clk_i),
        .rstn_i(rst_s2_reg),
        .prog(prog),
        .addr_i(addr_i),
        .rdata_o(rd_byte)
    );

    // Each rise flips a marker: the byte from the last fall is now stale
    always_ff @(posedge clk_i or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            rise_tog_reg <= 1'b0;
        end else begin
            rise_tog_reg <= ~rise_tog_reg;
        end
    end

    // Fall presents the byte for the address taken at the rise
    always_ff @(negedge clk_i or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            dout_reg <= NVR_CLEAR_BYTE;
            fall_tog_reg <= 1'b1; // Unequal markers: not valid in reset
        end else begin
            dout_reg <= rd_byte;
            fall_tog_reg <= rise_tog_reg;
        end
    end

    // Valid once the fall has caught up with the last rise.
    // Two markers instead of gating with the clock keep the clock off data paths,
    // at the cost of one compare after the flops on this single output.
    assign valid_o = (rise_tog_reg == fall_tog_reg);
    assign first_read_byte_o = dout_reg;
    assign jtag_busy_o = st_reg.busy;

    // Programming steps, one per cycle once a request is taken
    sequence s_prog_req;
        (st_reg.state == NVR_PG_IDLE) && jtag_prog_i;
    endsequence
    sequence s_erase_step;
        prog.erase && jtag_busy_o;
    endsequence
    sequence s_write_step;
        prog.write && jtag_busy_o;
    endsequence
    sequence s_done_step;
        !jtag_busy_o && (st_reg.state == NVR_PG_IDLE);
    endsequence

    chk_erase_then_write: assert property (@(posedge clk_i) disable iff (!rst_s2_reg)
        prog.erase |=> prog.write)
        else $error("Erase not followed by write");
    chk_prog_sequence: assert property (@(posedge clk_i) disable iff (!rst_s2_reg)
        s_prog_req |=> s_erase_step ##1 s_write_step ##1 s_done_step)
        else $error("Program sequence wrong");
    // A request while busy must not retarget the bank in flight
    chk_busy_holds_bank: assert property (@(posedge clk_i) disable iff (!rst_s2_reg)
        (st_reg.busy && jtag_prog_i) |=> (st_reg.bank == $past(st_reg.bank)))
        else $error("Request taken while busy");
    // Unprogrammed banks read unknown, hence case equality
    chk_byte_at_fall: assert property (@(negedge clk_i) disable iff (!rst_s2_reg)
        $past(rst_s2_reg) |-> (first_read_byte_o === $past(rd_byte)))
        else $error("Byte not presented at falling edge");
    // Sampled just before a fall: the high phase never shows valid
    chk_high_phase_invalid: assert property (@(negedge clk_i) disable iff (!rst_s2_reg)
        !valid_o)
        else $error("Valid during high phase");
    // Sampled just before a rise: the low phase always shows valid
    chk_low_phase_valid: assert property (@(posedge clk_i) disable iff (!rst_s2_reg)
        $past(rst_s2_reg) |-> valid_o)
        else $error("Byte not valid before rise");
endmodule : nvr_byte_store
`default_nettype wire

// [verification/nvr_core_reader.sv]
`timescale 1ns/1ns
`default_nettype none
// Core-side user logic reading the store one byte at a time
module nvr_core_reader (
    input wire logic clk_i, // Access clock
    input wire nvr_pkg::nvr_addr_t want_i, // Next address
    input wire nvr_pkg::nvr_byte_t byte_i, // Byte from store
    input wire logic valid_i, // Byte valid flag
    output nvr_pkg::nvr_addr_t addr_o, // Address to store
    output nvr_pkg::nvr_byte_t got_o // Last byte taken
);
    import nvr_pkg::*;
    // Address moves just after a rise, held a whole cycle
    always_ff @(posedge clk_i) addr_o <= want_i;
    // Sample after the fall only; the high phase holds no valid byte
    always begin
        @(negedge clk_i);
        #1;
        if (valid_i === 1'b1) got_o = byte_i;
    end
endmodule : nvr_core_reader
`default_nettype wire

// [verification/nvr_byte_store_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module nvr_byte_store_bench;
    import nvr_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic jtag_prog_i = 1'b0;
    nvr_bank_t jtag_bank_i = '0;
    nvr_bank_word_t jtag_data_i = '0;
    nvr_addr_t want = '0;
    nvr_addr_t addr_i;
    nvr_byte_t first_read_byte_o, got;
    logic valid_o, jtag_busy_o;
    nvr_byte_t bank_key [NVR_BANKS];
    int errors = 0;
    int checked = 0;
    always #2 clk_i = ~clk_i;
    nvr_byte_store dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .first_read_byte_o(first_read_byte_o), .valid_o(valid_o), .jtag_prog_i(jtag_prog_i),
        .jtag_bank_i(jtag_bank_i), .jtag_data_i(jtag_data_i), .jtag_busy_o(jtag_busy_o));
    nvr_core_reader core (.clk_i(clk_i), .want_i(want), .byte_i(first_read_byte_o),
        .valid_i(valid_o), .addr_o(addr_i), .got_o(got));
    // Byte pattern: position XOR a per-bank key
    function automatic nvr_byte_t pat(input nvr_addr_t a);
        return {1'b0, a} ^ bank_key[a[6:4]];
    endfunction : pat
    task automatic tally_and_finish;
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_byte(input nvr_byte_t g, input nvr_byte_t e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("Error %0t byte %h expected %h", $time, g, e);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("Error %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk_bit
    // Whole-bank program, then a request while busy that must be ignored
    task automatic program_bank(input nvr_bank_t b);
        int i;
        @(posedge clk_i);
        jtag_prog_i <= 1'b1;
        jtag_bank_i <= b;
        want <= {b, 4'h0};
        for (i = 0; i < NVR_BYTES; i++) jtag_data_i[8*i +: 8] <= pat({b, 4'(i)});
        @(posedge clk_i);
        jtag_bank_i <= b ^ 3'h1;
        jtag_data_i <= ~jtag_data_i;
        @(posedge clk_i);
        jtag_prog_i <= 1'b0;
        #1 chk_bit(jtag_busy_o, 1'b1);
        @(negedge clk_i);
        #1 chk_byte(first_read_byte_o, NVR_ERASED_BYTE);
        i = 0;
        while (jtag_busy_o !== 1'b0 && i < 6) begin
            @(posedge clk_i);
            #1 i++;
        end
        if (jtag_busy_o !== 1'b0) begin
            errors++;
            $display("Error %0t busy never cleared", $time);
            tally_and_finish();
        end
    endtask : program_bank
    // Address in, byte valid in the low phase, invalid after the next rise
    task automatic read_byte(input nvr_addr_t a);
        @(posedge clk_i);
        want <= a;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        #1 chk_byte(got, pat(a));
        chk_bit(valid_o, 1'b1);
        @(posedge clk_i);
        #1 chk_bit(valid_o, 1'b0);
    endtask : read_byte
    initial begin
        int i;
        repeat (3) @(posedge clk_i);
        chk_bit(valid_o, 1'b0);
        chk_bit(jtag_busy_o, 1'b0);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (i = 0; i < NVR_BANKS; i++) begin
            bank_key[i] = 8'h5a + 8'(i * 17);
            program_bank(3'(i));
        end
        for (i = 0; i < 128; i++) read_byte(7'(i));
        read_byte(7'h7f);
        bank_key[2] = 8'ha5;
        program_bank(3'h2);
        for (i = 32; i < 64; i++) read_byte(7'(i));
        tally_and_finish();
    end
endmodule : nvr_byte_store_bench
`default_nettype wire
